// *** fwd_counter.sv ***
// overflow counter of the free running watchdog
module fwd_counter (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        tick,
   input  wire logic        clear,
   input  wire logic [1:0]  period_sel,
   output logic             overflow
);
   logic [18:0] count_q;

   function automatic logic [18:0] period_ticks(input logic [1:0] sel);
      case (sel)
         2'h0:    period_ticks = fwd_pkg::PERIOD_0_TICKS;
         2'h1:    period_ticks = fwd_pkg::PERIOD_1_TICKS;
         2'h2:    period_ticks = fwd_pkg::PERIOD_2_TICKS;
         default: period_ticks = fwd_pkg::PERIOD_3_TICKS;
      endcase
   endfunction : period_ticks

   // terminal tick restarts the period; this counter has no stop input, stop mode gates its tick upstream
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         count_q  <= 19'h0;
         overflow <= 1'b0;
      end else if (tick) begin
         if (count_q >= period_ticks(period_sel) - 19'h1) begin
            count_q  <= 19'h0;
            overflow <= 1'b1;
         end else begin
            count_q  <= count_q + 19'h1;
            overflow <= 1'b0;
         end
      end else begin
         overflow <= 1'b0;
      end
   end
endmodule : fwd_counter

// *** fwd_pkg.sv ***
// constants of the free running watchdog
//
// Contract
// - count starts after reset and slow clock
// - software has no way to stop counter
// - first overflow raises non-maskable interrupt
// - second uncleared overflow asserts watchdog reset
// - key pair on pointer 0 then 1 clears
// - pointer zeroed at reset, overflow; toggles on write
// - clear register read returns pointer in bit 0
// - mismatched key not accepted, pointer still toggles
// - key writes ignored until slow clock oscillates
// - period field selects four periods, resets 10
// - counting halts in stop mode
// - counting continues in halt; interrupt wakes halt
package fwd_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [15:0] ADDR_CLEAR_KEY  = 16'hf00e;
   localparam logic [15:0] ADDR_PERIOD_SEL = 16'hf00f;
   localparam logic [15:0] ADDR_IRQ_STATUS = 16'hf010;
   localparam logic [15:0] ADDR_IRQ_MASK   = 16'hf011;
   localparam logic [7:0]  CLEAR_KEY_RESET = 8'h00;
   localparam logic [1:0]  PERIOD_RESET    = 2'h2;
   localparam logic [7:0]  KEY_FIRST       = 8'h5a;
   localparam logic [7:0]  KEY_SECOND      = 8'ha5;
   localparam int          POINTER_BIT     = 0;
   localparam int          STAT_OVF_BIT    = 0;
   localparam int          STAT_WDRST_BIT  = 1;
   localparam logic [1:0]  MASK_RESET      = 2'h3;

   // ****************************************************************
   // timing, counted in slow clock ticks (32768 Hz)
   // ****************************************************************
   localparam int          SLOW_CLOCK_HZ   = 32768;
   localparam int          PERIOD_0_MS     = 125;
   localparam int          PERIOD_1_MS     = 500;
   localparam int          PERIOD_2_MS     = 2000;
   localparam int          PERIOD_3_MS     = 8000;
   // the longest period is one tick past what 18 bits hold, hence 19 bits
   localparam logic [18:0] PERIOD_0_TICKS  = 19'(PERIOD_0_MS * SLOW_CLOCK_HZ / 1000);
   localparam logic [18:0] PERIOD_1_TICKS  = 19'(PERIOD_1_MS * SLOW_CLOCK_HZ / 1000);
   localparam logic [18:0] PERIOD_2_TICKS  = 19'(PERIOD_2_MS * SLOW_CLOCK_HZ / 1000);
   localparam logic [18:0] PERIOD_3_TICKS  = 19'(PERIOD_3_MS * SLOW_CLOCK_HZ / 1000);

   typedef enum logic [2:0] {
      ST_COUNT = 3'b001,
      ST_WARN  = 3'b010,
      ST_RESET = 3'b100
   } fwd_state_t;
endpackage : fwd_pkg

// *** fwd_watchdog.sv ***
// top of the free running watchdog: register port, key logic, escalation
//
// Added by the designer: the address-and-strobe port.
module fwd_watchdog (
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        SLOW_TICK,
   input  wire logic        SLOW_CLOCK_RUNNING,
   input  wire logic        STOP_MODE,
   input  wire logic        HALT_MODE,
   input  wire logic [15:0] ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   output logic             IRQ,
   output logic             WATCHDOG_OVERFLOW_IRQ,
   output logic             HALT_RELEASE,
   output logic             WATCHDOG_RESET
);
   // ****************************************************************
   // register state
   // ****************************************************************
   logic                    clear_toggle_pointer_q;
   logic [1:0]              period_select_q;
   logic [1:0]              status_q;
   logic [1:0]              mask_q;
   logic                    first_ok_q;
   logic                    counter_clear;
   logic                    count_tick;
   logic                    overflow;
   logic                    key_write;
   fwd_pkg::fwd_state_t     state_q;

   // key writes only count once the slow oscillator runs
   assign key_write = WR && (ADDR == fwd_pkg::ADDR_CLEAR_KEY)
                      && SLOW_CLOCK_RUNNING;
   // counting needs the slow clock and no stop; halt keeps it running
   assign count_tick = SLOW_TICK && SLOW_CLOCK_RUNNING && !STOP_MODE;
   assign counter_clear = key_write && clear_toggle_pointer_q && first_ok_q
                          && (WDATA == fwd_pkg::KEY_SECOND);

   fwd_counter u_counter (
      .clk        (CORE_CLK),
      .rst        (RST),
      .tick       (count_tick),
      .clear      (counter_clear),
      .period_sel (period_select_q),
      .overflow   (overflow)
   );

   // ****************************************************************
   // toggle pointer and key acceptance
   // ****************************************************************
   always_ff @(posedge CORE_CLK) begin
      if (RST || overflow) begin
         clear_toggle_pointer_q <= 1'b0;
      end else if (key_write) begin
         clear_toggle_pointer_q <= !clear_toggle_pointer_q;
      end
   end

   // a first key only counts when written with the pointer at zero
   always_ff @(posedge CORE_CLK) begin
      if (RST || overflow) begin
         first_ok_q <= 1'b0;
      end else if (key_write) begin
         first_ok_q <= !clear_toggle_pointer_q
                       && (WDATA == fwd_pkg::KEY_FIRST);
      end
   end

   // ****************************************************************
   // period select and interrupt registers
   // ****************************************************************
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         period_select_q <= fwd_pkg::PERIOD_RESET;
      end else if (WR && ADDR == fwd_pkg::ADDR_PERIOD_SEL) begin
         period_select_q <= WDATA[1:0];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         mask_q <= fwd_pkg::MASK_RESET;
      end else if (WR && ADDR == fwd_pkg::ADDR_IRQ_MASK) begin
         mask_q <= WDATA[1:0];
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         status_q <= 2'h0;
      end else begin
         status_q <= (status_q & ~((WR && ADDR == fwd_pkg::ADDR_IRQ_STATUS)
                                   ? WDATA[1:0] : 2'h0))
                     | {overflow && state_q == fwd_pkg::ST_WARN,
                        overflow && state_q == fwd_pkg::ST_COUNT};
      end
   end

   // ****************************************************************
   // overflow escalation
   // ****************************************************************
   // a valid clear after the first overflow disarms the reset stage
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state_q <= fwd_pkg::ST_COUNT;
      end else begin
         case (state_q)
            fwd_pkg::ST_COUNT: begin
               if (overflow) begin
                  state_q <= fwd_pkg::ST_WARN;
               end
            end
            fwd_pkg::ST_WARN: begin
               if (counter_clear) begin
                  state_q <= fwd_pkg::ST_COUNT;
               end else if (overflow) begin
                  state_q <= fwd_pkg::ST_RESET;
               end
            end
            fwd_pkg::ST_RESET: begin
               state_q <= fwd_pkg::ST_RESET;
            end
            default: begin
               state_q <= fwd_pkg::ST_COUNT;
            end
         endcase
      end
   end

   // ****************************************************************
   // outputs, all registered
   // ****************************************************************
   // the non-maskable request ignores the mask; only IRQ honours it
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         WATCHDOG_OVERFLOW_IRQ <= 1'b0;
         HALT_RELEASE          <= 1'b0;
         WATCHDOG_RESET        <= 1'b0;
         IRQ                   <= 1'b0;
      end else begin
         WATCHDOG_OVERFLOW_IRQ <= overflow && state_q == fwd_pkg::ST_COUNT;
         HALT_RELEASE          <= overflow && state_q == fwd_pkg::ST_COUNT
                                  && HALT_MODE;
         WATCHDOG_RESET        <= state_q == fwd_pkg::ST_RESET
                                  || (overflow && state_q == fwd_pkg::ST_WARN
                                      && !counter_clear);
         IRQ                   <= |(status_q & mask_q);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         if (ADDR == fwd_pkg::ADDR_CLEAR_KEY) begin
            RDATA <= {7'h00, clear_toggle_pointer_q};
         end else if (ADDR == fwd_pkg::ADDR_PERIOD_SEL) begin
            RDATA <= {6'h00, period_select_q};
         end else if (ADDR == fwd_pkg::ADDR_IRQ_STATUS) begin
            RDATA <= {6'h00, status_q};
         end else if (ADDR == fwd_pkg::ADDR_IRQ_MASK) begin
            RDATA <= {6'h00, mask_q};
         end else begin
            RDATA <= 8'h00;
         end
      end else begin
         RDATA <= 8'h00;
      end
   end
endmodule : fwd_watchdog

// *** fwd_watchdog_properties.sv ***
// port assertions of the free running watchdog
module fwd_watchdog_properties (
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        STOP_MODE,
   input wire logic [15:0] ADDR,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [7:0]  RDATA,
   input wire logic        IRQ,
   input wire logic        WATCHDOG_OVERFLOW_IRQ,
   input wire logic        HALT_RELEASE,
   input wire logic        WATCHDOG_RESET
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data not zero outside a read");
   AST_PTR_READ: assert property (RD && ADDR == fwd_pkg::ADDR_CLEAR_KEY |=> RDATA[7:1] == 7'h00)
      else $error("key read shows more than the pointer");
   AST_OVF_PULSE: assert property (WATCHDOG_OVERFLOW_IRQ |=> !WATCHDOG_OVERFLOW_IRQ)
      else $error("overflow request longer than one cycle");
   AST_HALT_WAKE: assert property (HALT_RELEASE |-> WATCHDOG_OVERFLOW_IRQ)
      else $error("halt release without overflow request");
   AST_STOP_HOLD: assert property (STOP_MODE [*4] |-> !WATCHDOG_OVERFLOW_IRQ)
      else $error("overflow while stopped");
   AST_WDRST_STICKY: assert property (WATCHDOG_RESET |=> WATCHDOG_RESET)
      else $error("watchdog reset dropped before reset");
   AST_RESET_QUIET: assert property ($fell(RST) |-> !WATCHDOG_RESET && !IRQ)
      else $error("outputs active after reset");
   // status changes only by overflow or by a write, so a held irq needs no write
   AST_IRQ_STICKY: assert property (IRQ && !WR && !$past(WR) |=> IRQ)
      else $error("interrupt fell without a write");
endmodule : fwd_watchdog_properties

bind fwd_watchdog fwd_watchdog_properties i_fwd_watchdog_properties (
   .CORE_CLK(CORE_CLK), .RST(RST), .STOP_MODE(STOP_MODE), .ADDR(ADDR), .WR(WR), .RD(RD),
   .RDATA(RDATA), .IRQ(IRQ), .WATCHDOG_OVERFLOW_IRQ(WATCHDOG_OVERFLOW_IRQ),
   .HALT_RELEASE(HALT_RELEASE), .WATCHDOG_RESET(WATCHDOG_RESET));

// *** tb_fwd_watchdog.sv ***
// self-checking bench of the free running watchdog
module tb_fwd_watchdog;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CORE_CLK = 1'b0, RST = 1'b1, SLOW_TICK = 1'b0, SLOW_CLOCK_RUNNING = 1'b1;
   logic        STOP_MODE = 1'b0, HALT_MODE = 1'b0, WR = 1'b0, RD = 1'b0;
   logic [15:0] ADDR = 16'h0000;
   logic [7:0]  WDATA = 8'h00, RDATA;
   logic        IRQ, WATCHDOG_OVERFLOW_IRQ, HALT_RELEASE, WATCHDOG_RESET;
   int          err_count = 0, tests_run = 0, cycles = 0, hits;
   fwd_watchdog i_fwd_watchdog (.CORE_CLK(CORE_CLK), .RST(RST), .SLOW_TICK(SLOW_TICK),
      .SLOW_CLOCK_RUNNING(SLOW_CLOCK_RUNNING), .STOP_MODE(STOP_MODE), .HALT_MODE(HALT_MODE),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
      .WATCHDOG_OVERFLOW_IRQ(WATCHDOG_OVERFLOW_IRQ), .HALT_RELEASE(HALT_RELEASE),
      .WATCHDOG_RESET(WATCHDOG_RESET));
   // ****************************************************************
   // clock, slow tick every other cycle, run limit
   // ****************************************************************
   initial forever #10 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK) begin
      SLOW_TICK <= ~SLOW_TICK;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count++;
         wrap_up();
      end
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CORE_CLK);
      WR <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] a, input logic [7:0] exp, input string name);
      @(posedge CORE_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      #1 chk(name, exp, RDATA);
   endtask : rd
   task clr;
      wr(fwd_pkg::ADDR_CLEAR_KEY, fwd_pkg::KEY_FIRST);
      wr(fwd_pkg::ADDR_CLEAR_KEY, fwd_pkg::KEY_SECOND);
   endtask : clr
   task run(input int n);
      hits = 0;
      repeat (n) begin
         @(posedge CORE_CLK);
         #1 if (WATCHDOG_OVERFLOW_IRQ === 1'b1) hits++;
      end
   endtask : run
   task wait_for(input bit esc, input int n);
      int k;
      k = 0;
      while ((esc ? WATCHDOG_RESET : WATCHDOG_OVERFLOW_IRQ) !== 1'b1 && k < n) begin
         @(posedge CORE_CLK);
         #1 k++;
      end
      chk("event", 8'h01, {7'h00, esc ? WATCHDOG_RESET : WATCHDOG_OVERFLOW_IRQ});
   endtask : wait_for
   task t_regs;
      rd(fwd_pkg::ADDR_CLEAR_KEY, 8'h00, "key reg");
      rd(fwd_pkg::ADDR_PERIOD_SEL, 8'h02, "period");
      rd(fwd_pkg::ADDR_IRQ_MASK, 8'h03, "mask");
      rd(16'hf012, 8'h00, "unmapped");
      wr(fwd_pkg::ADDR_PERIOD_SEL, 8'h03);
      rd(fwd_pkg::ADDR_PERIOD_SEL, 8'h03, "period");
      wr(fwd_pkg::ADDR_PERIOD_SEL, 8'h00);
      rd(fwd_pkg::ADDR_PERIOD_SEL, 8'h00, "period");
   endtask : t_regs
   task t_ptr;
      wr(fwd_pkg::ADDR_CLEAR_KEY, 8'h00);
      rd(fwd_pkg::ADDR_CLEAR_KEY, 8'h01, "pointer");
      @(posedge CORE_CLK) SLOW_CLOCK_RUNNING <= 1'b0;
      wr(fwd_pkg::ADDR_CLEAR_KEY, 8'h33);
      rd(fwd_pkg::ADDR_CLEAR_KEY, 8'h01, "pointer");
      @(posedge CORE_CLK) SLOW_CLOCK_RUNNING <= 1'b1;
      wr(fwd_pkg::ADDR_CLEAR_KEY, 8'h77);
      rd(fwd_pkg::ADDR_CLEAR_KEY, 8'h00, "pointer");
   endtask : t_ptr
   task t_clear;
      repeat (2) begin
         clr();
         run(6000);
         chk("overflows", 8'h00, 8'(hits));
      end
   endtask : t_clear
   task t_bad;
      @(posedge CORE_CLK) HALT_MODE <= 1'b1;
      clr();
      run(3000);
      // second key lands on the wrong pointer, so this pair must not clear
      wr(fwd_pkg::ADDR_CLEAR_KEY, fwd_pkg::KEY_FIRST);
      wr(fwd_pkg::ADDR_CLEAR_KEY, fwd_pkg::KEY_FIRST);
      wr(fwd_pkg::ADDR_CLEAR_KEY, fwd_pkg::KEY_SECOND);
      wait_for(1'b0, 5400);
      chk("halt release", 8'h01, {7'h00, HALT_RELEASE});
      @(posedge CORE_CLK) HALT_MODE <= 1'b0;
      rd(fwd_pkg::ADDR_CLEAR_KEY, 8'h00, "pointer");
      rd(fwd_pkg::ADDR_IRQ_STATUS, 8'h01, "status");
      chk("irq", 8'h01, {7'h00, IRQ});
      wr(fwd_pkg::ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(posedge CORE_CLK);
      #1 chk("irq", 8'h00, {7'h00, IRQ});
      wr(fwd_pkg::ADDR_IRQ_MASK, 8'h03);
      repeat (2) @(posedge CORE_CLK);
      #1 chk("irq", 8'h01, {7'h00, IRQ});
      wr(fwd_pkg::ADDR_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge CORE_CLK);
      #1 chk("irq", 8'h00, {7'h00, IRQ});
   endtask : t_bad
   task t_escal;
      wait_for(1'b1, 8400);
      @(posedge CORE_CLK) RST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      RST <= 1'b0;
      #1 chk("watchdog reset", 8'h00, {7'h00, WATCHDOG_RESET});
      rd(fwd_pkg::ADDR_PERIOD_SEL, 8'h02, "period");
   endtask : t_escal
   task t_stop;
      wr(fwd_pkg::ADDR_PERIOD_SEL, 8'h00);
      clr();
      @(posedge CORE_CLK) STOP_MODE <= 1'b1;
      run(9000);
      @(posedge CORE_CLK) STOP_MODE <= 1'b0;
      chk("overflows", 8'h00, 8'(hits));
   endtask : t_stop
   initial begin
      repeat (2) @(posedge CORE_CLK);
      RST <= 1'b0;
      t_regs();
      t_ptr();
      t_clear();
      t_bad();
      t_escal();
      t_stop();
      wrap_up();
   end
endmodule : tb_fwd_watchdog
